/* File: hw/io_ports_cfg.svh */
// register offsets, field positions, reset values and port count for the i/o block
`ifndef IO_PORTS_CFG_SVH
`define IO_PORTS_CFG_SVH
`define ADDR_W 12
`define PORT_A_ADDR 12'h080
`define PORT_B_ADDR 12'h081
`define PORT_C_ADDR 12'h082
`define PORT_D_ADDR 12'h083
`define CLR_RISE_ADDR 12'h089
`define CLR_FALL_ADDR 12'h08A
`define CTRL_ADDR 12'h08F
`define PORT_RESET 8'hFF
`define CTRL_RESET 8'h00
`define CTRL_WR_MASK 8'h1F
`define BIT_MODE_LO 0
`define BIT_MODE_HI 1
`define BIT_EN_FALL 2
`define BIT_EN_RISE 3
`define BIT_EN_OVF 4
`define BIT_FALL 5
`define BIT_RISE 6
`define BIT_OVF 7
`define NUM_PORTS 4
`endif

/* File: hw/io_ports_pkg.sv */
// types shared by the i/o block and its surroundings
package io_ports_pkg;
   typedef enum logic [1:0] {
      MODE_INTERVAL = 2'h0,
      MODE_PULSE_GEN = 2'h1,
      MODE_EVENT = 2'h2,
      MODE_PULSE_WIDTH = 2'h3
   } counter_mode_e;
   // one cpu access on the internal bus
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } cpu_req_s;
   // all pins of one 8-bit port
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } port_drive_s;
endpackage

/* File: hw/io_ports_edge_detect_irq.sv */
// quasi-bidirectional ports, control register, edge flags and irq merge
`include "io_ports_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - four 8-bit ports, each line independently input or output.
// - register bit 0 drives line low; 1 releases it to a passive pull-up.
// - pull-up removable per port group and for the counter line at build.
// - writing 1 makes a line an input; reads return the pin level.
// - a written pattern sets outputs: 1 high, 0 low.
// - reset loads all ones into every port register.
// - five writable control bits, three read-only status bits.
// - control bits pick counter mode and enable three interrupt sources.
// - reset clears the whole control register.
// - edge detection on port A lines 0 and 1 always runs.
// - edges up to half the phase-two rate are captured.
// - rising edge on port A line 0 sets control bit 6.
// - irq raised while bit 6 and enable bit 3 are both set.
// - any write to 089 clears the rising-edge flag, data ignored.
// - falling edge on port A line 1 sets control bit 5.
// - irq raised while bit 5 and enable bit 2 are both set.
// - any write to 08A clears the falling-edge flag, data ignored.
// - irq is the OR of three enabled flags.
// - counter overflow sets bit 7; with enable bit 4 it raises irq.
// - flag-clear addresses store nothing and read back nothing.
module io_ports_edge_detect_irq #(
   parameter logic [3:0] PULLUP_FITTED = 4'hF,
   parameter logic COUNTER_IO_LINE_PULLUP_FITTED = 1'b1
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // phase-two enable from the clock divider
   input wire logic phi2_en_i,
   // cpu internal bus
   input wire io_ports_pkg::cpu_req_s cpu_req_i,
   output logic [7:0] cpu_rdata_o,
   // port pins, open-drain style
   input wire logic [31:0] port_pin_i,
   output io_ports_pkg::port_drive_s [3:0] port_drive_o,
   output logic [3:0] port_pullup_o,
   output logic counter_io_line_pullup_o,
   // counter block
   input wire logic counter_ovf_i,
   input wire logic counter_ovf_clr_i,
   output io_ports_pkg::counter_mode_e counter_mode_o,
   // interrupt request to the cpu
   output logic irq_o
);
   import io_ports_pkg::*;

   logic [7:0] port_q [0:3];
   logic [31:0] pin_meta_q;
   logic [31:0] pin_sync_q;
   logic [1:0] edge_prev_q;
   logic [4:0] ctrl_q;
   logic rise_q;
   logic fall_q;
   logic ovf_q;
   logic rise_evt;
   logic fall_evt;
   logic clr_rise;
   logic clr_fall;

   ////////////////////////////////////////////////////////////////////////////
   // port registers and pin drive, one generate slice per port
   genvar gp;
   generate
      for (gp = 0; gp < `NUM_PORTS; gp++) begin : g_port
         // all ones at reset so every line starts as a released input
         always_ff @(posedge core_clk_i) begin
            if (!nrst_i) begin
               port_q[gp] <= `PORT_RESET;
            end else if (cpu_req_i.wr &&
                         cpu_req_i.addr == `PORT_A_ADDR + 12'(gp)) begin
               port_q[gp] <= cpu_req_i.wdata;
            end
         end
         // only ever pull low; a 1 leaves the line to the pull-up
         assign port_drive_o[gp].out = 8'h00;
         assign port_drive_o[gp].oe = ~port_q[gp];
         assign port_pullup_o[gp] = PULLUP_FITTED[gp];
      end
   endgenerate
   assign counter_io_line_pullup_o = COUNTER_IO_LINE_PULLUP_FITTED;

   ////////////////////////////////////////////////////////////////////////////
   // two-flop synchroniser on every pin before anything reads it
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         pin_meta_q <= 32'hFFFFFFFF;
         pin_sync_q <= 32'hFFFFFFFF;
      end else begin
         pin_meta_q <= port_pin_i;
         pin_sync_q <= pin_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // edge detect, sampled on phase-two so edges at half that rate are seen
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         edge_prev_q <= 2'h3;
      end else if (phi2_en_i) begin
         edge_prev_q <= pin_sync_q[1:0];
      end
   end
   // runs regardless of the line's port direction
   assign rise_evt = phi2_en_i && pin_sync_q[0] && !edge_prev_q[0];
   assign fall_evt = phi2_en_i && !pin_sync_q[1] && edge_prev_q[1];

   // command addresses: any write, data discarded
   assign clr_rise = cpu_req_i.wr && cpu_req_i.addr == `CLR_RISE_ADDR;
   assign clr_fall = cpu_req_i.wr && cpu_req_i.addr == `CLR_FALL_ADDR;

   ////////////////////////////////////////////////////////////////////////////
   // status flags; set beats a clear in the same cycle so no edge is lost
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         rise_q <= 1'b0;
      end else if (rise_evt) begin
         rise_q <= 1'b1;
      end else if (clr_rise) begin
         rise_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         fall_q <= 1'b0;
      end else if (fall_evt) begin
         fall_q <= 1'b1;
      end else if (clr_fall) begin
         fall_q <= 1'b0;
      end
   end

   // overflow flag: counter block says when to set and when to clear
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         ovf_q <= 1'b0;
      end else if (counter_ovf_i) begin
         ovf_q <= 1'b1;
      end else if (counter_ovf_clr_i) begin
         ovf_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control bits; status positions ignore written data
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         ctrl_q <= 5'(`CTRL_RESET);
      end else if (cpu_req_i.wr && cpu_req_i.addr == `CTRL_ADDR) begin
         ctrl_q <= cpu_req_i.wdata[4:0];
      end
   end
   assign counter_mode_o =
      counter_mode_e'(ctrl_q[`BIT_MODE_HI:`BIT_MODE_LO]);

   ////////////////////////////////////////////////////////////////////////////
   // read data, registered; command addresses and holes read zero
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         cpu_rdata_o <= 8'h00;
      end else if (cpu_req_i.rd) begin
         unique case (cpu_req_i.addr)
            `PORT_A_ADDR: cpu_rdata_o <= pin_sync_q[7:0];
            `PORT_B_ADDR: cpu_rdata_o <= pin_sync_q[15:8];
            `PORT_C_ADDR: cpu_rdata_o <= pin_sync_q[23:16];
            `PORT_D_ADDR: cpu_rdata_o <= pin_sync_q[31:24];
            `CTRL_ADDR: cpu_rdata_o <= {ovf_q, rise_q, fall_q, ctrl_q};
            default: cpu_rdata_o <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // level irq, held until every enabled flag clears or is masked
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= (ovf_q && ctrl_q[`BIT_EN_OVF])
               || (rise_q && ctrl_q[`BIT_EN_RISE])
               || (fall_q && ctrl_q[`BIT_EN_FALL]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_rise_seen;
      rise_evt;
   endsequence
   sequence s_flag_set;
      ##1 rise_q;
   endsequence

   property p_rise_sets;
      @(posedge core_clk_i) disable iff (!nrst_i) s_rise_seen |-> s_flag_set;
   endproperty
   a_rise_sets: assert property (p_rise_sets) else $error("rise lost");

   property p_fall_sets;
      @(posedge core_clk_i) disable iff (!nrst_i) fall_evt |=> fall_q;
   endproperty
   a_fall_sets: assert property (p_fall_sets) else $error("fall lost");

   property p_clr_rise;
      @(posedge core_clk_i) disable iff (!nrst_i)
         clr_rise && !rise_evt |=> !rise_q;
   endproperty
   a_clr_rise: assert property (p_clr_rise) else $error("no clear");

   property p_clr_fall;
      @(posedge core_clk_i) disable iff (!nrst_i)
         clr_fall && !fall_evt |=> !fall_q;
   endproperty
   a_clr_fall: assert property (p_clr_fall) else $error("no clear");

   property p_irq_rise;
      @(posedge core_clk_i) disable iff (!nrst_i)
         rise_q && ctrl_q[`BIT_EN_RISE] |=> irq_o;
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("no irq");

   property p_irq_fall;
      @(posedge core_clk_i) disable iff (!nrst_i)
         fall_q && ctrl_q[`BIT_EN_FALL] |=> irq_o;
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("no irq");

   property p_irq_quiet;
      @(posedge core_clk_i) disable iff (!nrst_i)
         !(ovf_q && ctrl_q[`BIT_EN_OVF]) && !(rise_q && ctrl_q[`BIT_EN_RISE])
         && !(fall_q && ctrl_q[`BIT_EN_FALL]) |=> !irq_o;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("spurious");

   property p_ctrl_wr;
      @(posedge core_clk_i) disable iff (!nrst_i)
         cpu_req_i.wr && cpu_req_i.addr == `CTRL_ADDR
         |=> ctrl_q == $past(cpu_req_i.wdata[4:0]);
   endproperty
   a_ctrl_wr: assert property (p_ctrl_wr) else $error("ctrl write");

   property p_port_drive;
      @(posedge core_clk_i) disable iff (!nrst_i)
         cpu_req_i.wr && cpu_req_i.addr == `PORT_B_ADDR
         |=> port_drive_o[1].oe == ~$past(cpu_req_i.wdata);
   endproperty
   a_port_drive: assert property (p_port_drive) else $error("drive");

   property p_set_wins;
      @(posedge core_clk_i) disable iff (!nrst_i)
         rise_evt && clr_rise |=> rise_q;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("edge lost");

   ////////////////////////////////////////////////////////////////////////////
   // checks on the flags that tests reach least often
   // a flag must never set from nothing; a false edge after reset would
   // raise an irq that software cannot explain
   property p_rise_quiet;
      @(posedge core_clk_i) disable iff (!nrst_i)
         !rise_q && !rise_evt |=> !rise_q;
   endproperty
   a_rise_quiet: assert property (p_rise_quiet) else $error("rise");

   property p_fall_quiet;
      @(posedge core_clk_i) disable iff (!nrst_i)
         !fall_q && !fall_evt |=> !fall_q;
   endproperty
   a_fall_quiet: assert property (p_fall_quiet) else $error("fall");

   property p_fall_wins;
      @(posedge core_clk_i) disable iff (!nrst_i)
         fall_evt && clr_fall |=> fall_q;
   endproperty
   a_fall_wins: assert property (p_fall_wins) else $error("lost");

   // overflow: the counter's pulse, then the flag one cycle on
   sequence s_ovf_seen;
      counter_ovf_i;
   endsequence
   sequence s_ovf_flag;
      ##1 ovf_q;
   endsequence

   property p_ovf_sets;
      @(posedge core_clk_i) disable iff (!nrst_i) s_ovf_seen |-> s_ovf_flag;
   endproperty
   a_ovf_sets: assert property (p_ovf_sets) else $error("ovf lost");

   property p_ovf_clr;
      @(posedge core_clk_i) disable iff (!nrst_i)
         counter_ovf_clr_i && !counter_ovf_i |=> !ovf_q;
   endproperty
   a_ovf_clr: assert property (p_ovf_clr) else $error("ovf clear");

   property p_irq_ovf;
      @(posedge core_clk_i) disable iff (!nrst_i)
         ovf_q && ctrl_q[`BIT_EN_OVF] |=> irq_o;
   endproperty
   a_irq_ovf: assert property (p_irq_ovf) else $error("no irq");

   ////////////////////////////////////////////////////////////////////////////
   // bus side: commands store nothing, status bits ignore writes
   property p_cmd_keeps;
      @(posedge core_clk_i) disable iff (!nrst_i)
         clr_rise || clr_fall |=> $stable(ctrl_q);
   endproperty
   a_cmd_keeps: assert property (p_cmd_keeps) else $error("stored");

   property p_cmd_rd0;
      @(posedge core_clk_i) disable iff (!nrst_i)
         cpu_req_i.rd && (cpu_req_i.addr == `CLR_RISE_ADDR
         || cpu_req_i.addr == `CLR_FALL_ADDR) |=> cpu_rdata_o == 8'h00;
   endproperty
   a_cmd_rd0: assert property (p_cmd_rd0) else $error("cmd");

   property p_status_ro;
      @(posedge core_clk_i) disable iff (!nrst_i)
         cpu_req_i.wr && cpu_req_i.addr == `CTRL_ADDR && !rise_evt
         |=> $stable(rise_q);
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status");

   property p_ctrl_read;
      @(posedge core_clk_i) disable iff (!nrst_i)
         cpu_req_i.rd && cpu_req_i.addr == `CTRL_ADDR
         |=> cpu_rdata_o[4:0] == $past(ctrl_q)
         && cpu_rdata_o[`BIT_RISE] == $past(rise_q);
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("read");

   // read data stands until the next read so a slow cpu still sees it
   property p_rd_holds;
      @(posedge core_clk_i) disable iff (!nrst_i)
         !cpu_req_i.rd |=> $stable(cpu_rdata_o);
   endproperty
   a_rd_holds: assert property (p_rd_holds) else $error("rdata");

   // reset values, checked without the disable so they are really seen
   property p_rst_port;
      @(posedge core_clk_i)
         !nrst_i |=> port_drive_o[0].oe == 8'h00
         && port_drive_o[3].oe == 8'h00;
   endproperty
   a_rst_port: assert property (p_rst_port) else $error("ports");

   property p_rst_ctrl;
      @(posedge core_clk_i)
         !nrst_i |=> ctrl_q == 5'h00 && !rise_q && !fall_q
         && !ovf_q && !irq_o;
   endproperty
   a_rst_ctrl: assert property (p_rst_ctrl) else $error("ctrl");
endmodule

/* File: verification/pin_load_model.sv */
// pin load model: pull-ups, device drivers and outside sources
module pin_load_model (
   // device side
   input wire io_ports_pkg::port_drive_s [3:0] drive_i,
   input wire logic [3:0] pullup_i,
   // outside sources
   input wire logic [31:0] ext_en_i,
   input wire logic [31:0] ext_val_i,
   // resolved levels
   output logic [31:0] pin_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import io_ports_pkg::*;
   // device low wins; a bare line with no pull-up shows no stale level
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         if (drive_i[i/8].oe[i%8])
            pin_o[i] = drive_i[i/8].out[i%8];
         else if (ext_en_i[i])
            pin_o[i] = ext_val_i[i];
         else
            pin_o[i] = pullup_i[i/8] ? 1'b1 : ~ext_val_i[i];
      end
   end
endmodule

/* File: verification/io_ports_edge_detect_irq_test.sv */
// self-checking bench for the i/o port block
`include "io_ports_cfg.svh"
module io_ports_edge_detect_irq_test;
   timeunit 1ns;
   timeprecision 100ps;
   import io_ports_pkg::*;
   typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] e;} row_s;
   logic clk = 0, nrst = 0, phi2 = 0, ovf = 0, ovf_clr = 0, cnt_pu, irq;
   cpu_req_s req = '0;
   logic [31:0] ext_en = '0, ext_val = '0, pins;
   logic [7:0] rdata;
   logic [3:0] pu;
   port_drive_s [3:0] drv;
   counter_mode_e mode;
   int miscompares = 0, checks = 0, cycles = 0;
   // port lines 0 and 1 of port a stay high so no edge flag sets here
   row_s rows [8] = '{'{12'h080, 8'hA7, 8'hA7}, '{12'h081, 8'h3C, 8'h3C},
      '{12'h082, 8'h00, 8'h00}, '{12'h083, 8'hFF, 8'hFF},
      '{12'h08F, 8'hFF, 8'h1F}, '{12'h08F, 8'hE2, 8'h02},
      '{12'h089, 8'h77, 8'h00}, '{12'h090, 8'h55, 8'h00}};

   io_ports_edge_detect_irq i_dut (.core_clk_i(clk), .nrst_i(nrst),
      .phi2_en_i(phi2), .cpu_req_i(req), .cpu_rdata_o(rdata),
      .port_pin_i(pins), .port_drive_o(drv), .port_pullup_o(pu),
      .counter_io_line_pullup_o(cnt_pu), .counter_ovf_i(ovf),
      .counter_ovf_clr_i(ovf_clr), .counter_mode_o(mode), .irq_o(irq));
   pin_load_model i_pins (.drive_i(drv), .pullup_i(pu), .ext_en_i(ext_en),
      .ext_val_i(ext_val), .pin_o(pins));

   ////////////////////////////////////////////////////////////////////////
   // clock, phase-two enable at half rate, hang guard
   always #2 clk = ~clk;
   always @(posedge clk) #1 phi2 = ~phi2;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         miscompares++;
         finish_test;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // drive just after an edge; an idle cycle between accesses
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(logic [11:0] a, logic [7:0] d);
      req = '{a, d, 1'b1, 1'b0};
      tick(1);
      req = '0;
      tick(1);
   endtask
   task automatic rd(logic [11:0] a, logic [7:0] e);
      req = '{a, 8'h00, 1'b0, 1'b1};
      tick(1);
      req = '0;
      chk($sformatf("read %h", a), e, rdata);
      tick(1);
   endtask
   task automatic chk_irq(logic e);
      chk("irq", {7'h00, e}, {7'h00, irq});
   endtask
   task automatic finish_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // reset values first, then the table, edges, overflow and a second reset
   initial begin
      tick(12);
      nrst = 1;
      tick(1);
      for (int i = 0; i < 4; i++) begin
         rd(`PORT_A_ADDR + 12'(i), `PORT_RESET);
         chk("oe", 8'h00, drv[i].oe);
      end
      rd(`CTRL_ADDR, `CTRL_RESET);
      chk("pullup", 8'h1F, {3'h0, cnt_pu, pu});
      chk_irq(1'b0);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         // port reads see the pin through two flops, so wait them out
         tick(2);
         rd(rows[i].a, rows[i].e);
         if (rows[i].a < 12'h084)
            chk("oe", ~rows[i].d, drv[rows[i].a[1:0]].oe);
      end
      for (int i = 0; i < 4; i++)
         wr(`PORT_A_ADDR + 12'(i), 8'hFF);
      for (int m = 0; m < 4; m++) begin
         wr(`CTRL_ADDR, 8'(m));
         chk("mode", 8'(m), 8'(mode));
      end
      // outside source on port b read back through the pins
      ext_en[15:8] = 8'hFF;
      ext_val[15:8] = 8'h5A;
      tick(3);
      rd(`PORT_B_ADDR, 8'h5A);
      ext_en = '0;
      // rising edge on line 0: low for two phase-two periods
      wr(`CTRL_ADDR, 8'h0C);
      ext_en[0] = 1'b1;
      tick(4);
      ext_en[0] = 1'b0;
      tick(8);
      rd(`CTRL_ADDR, 8'h4C);
      chk_irq(1'b1);
      wr(`CLR_RISE_ADDR, 8'hA5);
      rd(`CTRL_ADDR, 8'h0C);
      chk_irq(1'b0);
      // falling edge on line 1 made by the device's own output
      wr(`PORT_A_ADDR, 8'hFD);
      tick(8);
      rd(`CTRL_ADDR, 8'h2C);
      chk_irq(1'b1);
      wr(`CTRL_ADDR, 8'h08);
      chk_irq(1'b0);
      wr(`CLR_FALL_ADDR, 8'hFF);
      rd(`CTRL_ADDR, 8'h08);
      // overflow, then set and clear in the same cycle
      wr(`CTRL_ADDR, 8'h10);
      ovf = 1'b1;
      tick(1);
      ovf_clr = 1'b1;
      tick(1);
      ovf = 1'b0;
      ovf_clr = 1'b0;
      tick(2);
      rd(`CTRL_ADDR, 8'h90);
      chk_irq(1'b1);
      ovf_clr = 1'b1;
      tick(1);
      ovf_clr = 1'b0;
      tick(2);
      chk_irq(1'b0);
      // second reset in mid-run
      wr(`CTRL_ADDR, 8'h1F);
      wr(`PORT_D_ADDR, 8'h00);
      nrst = 1'b0;
      tick(2);
      nrst = 1'b1;
      tick(1);
      rd(`CTRL_ADDR, 8'h00);
      rd(`PORT_D_ADDR, 8'hFF);
      chk("oe", 8'h00, drv[3].oe);
      chk_irq(1'b0);
      finish_test;
   end
endmodule
